// *** rtl/sgs_pkg.sv ***
`default_nettype none
package sgs_pkg;
  // register offsets
  localparam logic [7:0] ADDR_FAMILY = 8'h00;
  localparam logic [7:0] ADDR_IDENT  = 8'h01;
  localparam logic [7:0] ADDR_GCTL0  = 8'h02;
  // field positions inside the 8-bit registers
  localparam int START_BIT   = 0;
  localparam int REV_LSB     = 1;
  localparam int ID_LSB      = 4;
  localparam int FPURGE_BIT  = 4;
  localparam int LPURGE_BIT  = 5;
  localparam int BACKOFF_BIT = 7;
  // global control 0 constant part: bit 6 reads 0, bits 3 and 2 read 1
  localparam logic [7:0] GCTL0_RSV_VAL = 8'h0C;
  localparam logic [7:0] READ_ZERO     = 8'h00;
  // serial management frame layout
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [4:0] HDR_LAST      = 5'h0B;
  localparam logic [4:0] TA_LAST       = 5'h01;
  localparam logic [4:0] DATA_LAST     = 5'h0F;
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  localparam logic [1:0] PHY_SEL       = 2'h3;
  // strap settling after reset release, in clocks
  localparam logic [1:0] STRAP_SETTLE  = 2'h3;
  // start-up mode from the two straps
  typedef enum logic [1:0] {MODE_AUTO, MODE_HOST_A, MODE_HOST_B, MODE_FACTORY} sgs_mode_e;
  // serial management frame receiver
  typedef enum logic [2:0] {SMI_PRE, SMI_ST, SMI_HDR, SMI_TA, SMI_DAT} sgs_smi_e;
  // power-on start sequencer
  typedef enum logic [2:0] {BOOT_STRAP, BOOT_ROM0, BOOT_ROM1, BOOT_ROM2, BOOT_DONE} sgs_boot_e;
endpackage
`default_nettype wire

// *** rtl/sgs_global_regs.sv ***
// Behaviour
// - host strap modes: start on start-bit write
// - host strap modes never start on own
// - writing start bit 0 halts switching
// - straps low: read EEPROM, then auto-start
// - no EEPROM answer: keep register defaults
// - EEPROM loads only if both ID checks pass
// - control 0 bit 7 selects alternate back-off
// - bit 5 starts learned purge, self-clears
// - learned purge hits learning-disabled ports only
// - bit 4 starts fixed purge, self-clears
// - fixed purge: single unicast port, learning off
// - 8-bit data, upper read zero, ignored
`timescale 1ns/100ps
`default_nettype none
module sgs_global_regs #(
  parameter logic [7:0] FAMILY_CODE   = 8'hA5, // arbitrary value
  parameter logic [3:0] CHIP_ID       = 4'h6,  // arbitrary value
  parameter logic [2:0] SILICON_REV   = 3'h1,  // arbitrary value
  parameter logic [3:0] ROM_ID_EXPECT = 4'h3   // arbitrary value
)(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       mode_strap_high,
  input  wire logic       mode_strap_low,
  input  wire logic       smiClk,
  input  wire logic       smiDataIn,
  output logic            smiDataOut,
  output logic            smiDataOe,
  output logic            romRdReq,
  output logic [7:0]      romAddr,
  input  wire logic [7:0] romRdData,
  input  wire logic       romRdDone,
  input  wire logic       romNoAck,
  input  wire logic [4:0] portLearnOff,
  input  wire logic       learnedPurgeDone,
  input  wire logic       fixedPurgeDone,
  output logic            learnedPurgeStart,
  output logic            fixedPurgeStart,
  output logic [4:0]      purgePortMask,
  output logic            switchEnable,
  output logic            backoffAltEnable
);

  // control and status state
  logic             startBit_q;     // start bit, drives switchEnable
  logic             backoff_q;      // alternate back-off select
  logic             lPurge_q;       // learned purge in progress
  logic             fPurge_q;       // fixed purge in progress
  logic             lPulse_q;       // learned purge kick
  logic             fPulse_q;       // fixed purge kick
  logic [4:0]       mask_q;         // learning-disabled ports at kick
  // register write strobe from the serial port
  logic             wrStb_q;
  logic [7:0]       wrAddr_q;
  logic [7:0]       wrData_q;
  // start sequencer
  sgs_pkg::sgs_boot_e bootState_q;
  logic [1:0]       settleCnt_q;
  logic             bootStart_q;    // one-cycle auto-start request
  logic             romLoad_q;      // one-cycle image load request
  logic [7:0]       romLoadData_q;
  logic             romRdReq_q;
  logic [7:0]       romAddr_q;
  // pin synchronisers, three stages each
  logic [2:0]       strapHiS_q;
  logic [2:0]       strapLoS_q;
  logic [2:0]       mdcS_q;
  logic [2:0]       mdioS_q;
  logic             mdcLvl_q;       // agreed clock level
  logic             mdcRise;        // agreed rising edge
  // serial frame receiver
  sgs_pkg::sgs_smi_e smiState_q;
  logic [5:0]       preCnt_q;
  logic [4:0]       bitCnt_q;
  logic [10:0]      hdr_q;
  logic [14:0]      wrShift_q;
  logic [15:0]      rdShift_q;
  logic [7:0]       frameAddr_q;
  logic             isRd_q;
  logic             isWr_q;
  logic             mdioOut_q;
  logic             mdioOe_q;
  // kick conditions for the two purges
  logic             lKick;
  logic             fKick;

  // strap pair to start-up mode
  function automatic sgs_pkg::sgs_mode_e strapMode(input logic hi, input logic lo);
    case ({hi, lo})
      2'h0:    strapMode = sgs_pkg::MODE_AUTO;
      2'h1:    strapMode = sgs_pkg::MODE_HOST_A;
      2'h2:    strapMode = sgs_pkg::MODE_HOST_B;
      default: strapMode = sgs_pkg::MODE_FACTORY;
    endcase
  endfunction

  // read value of one register; unmapped offsets read zero
  function automatic logic [7:0] regRead(input logic [7:0] addr);
    logic [7:0] v;
    v = sgs_pkg::READ_ZERO;
    case (addr)
      sgs_pkg::ADDR_FAMILY: v = FAMILY_CODE;
      sgs_pkg::ADDR_IDENT:
      begin
        v[sgs_pkg::ID_LSB +: 4]  = CHIP_ID;
        v[sgs_pkg::REV_LSB +: 3] = SILICON_REV;
        v[sgs_pkg::START_BIT]    = startBit_q;
      end
      sgs_pkg::ADDR_GCTL0:
      begin
        v = sgs_pkg::GCTL0_RSV_VAL;
        v[sgs_pkg::BACKOFF_BIT] = backoff_q;
        v[sgs_pkg::LPURGE_BIT]  = lPurge_q;
        v[sgs_pkg::FPURGE_BIT]  = fPurge_q;
      end
      default: v = sgs_pkg::READ_ZERO;
    endcase
    regRead = v;
  endfunction

  // pin synchronisers; only stages two and three are ever compared
  always_ff @(posedge clk_sys)
  begin
    strapHiS_q <= {strapHiS_q[1:0], mode_strap_high};
    strapLoS_q <= {strapLoS_q[1:0], mode_strap_low};
    mdcS_q     <= {mdcS_q[1:0], smiClk};
    mdioS_q    <= {mdioS_q[1:0], smiDataIn};
  end

  // management clock level follows only once stages two and three agree
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      mdcLvl_q <= 1'b1; // idle-high clock must not look like a rising edge after reset
    else if (mdcS_q[1] == mdcS_q[2])
      mdcLvl_q <= mdcS_q[2];
  end

  assign mdcRise = (mdcS_q[1] == mdcS_q[2]) && mdcS_q[2] && !mdcLvl_q;

  // start sequencer: straps decide between host start and auto start
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      bootState_q   <= sgs_pkg::BOOT_STRAP;
      settleCnt_q   <= 2'h0;
      bootStart_q   <= 1'b0;
      romLoad_q     <= 1'b0;
      romLoadData_q <= 8'h00;
      romRdReq_q    <= 1'b0;
      romAddr_q     <= 8'h00;
    end
    else
    begin
      bootStart_q <= 1'b0;
      romLoad_q   <= 1'b0;
      case (bootState_q)
        sgs_pkg::BOOT_STRAP:
        // straps are caught after release, once the synchroniser has filled
        begin
          if (settleCnt_q != sgs_pkg::STRAP_SETTLE)
            settleCnt_q <= settleCnt_q + 2'h1;
          else if (strapHiS_q[1] == strapHiS_q[2] && strapLoS_q[1] == strapLoS_q[2])
          begin
            if (strapMode(strapHiS_q[2], strapLoS_q[2]) == sgs_pkg::MODE_AUTO)
            begin
              bootState_q <= sgs_pkg::BOOT_ROM0;
              romRdReq_q  <= 1'b1;
              romAddr_q   <= sgs_pkg::ADDR_FAMILY;
            end
            else
              bootState_q <= sgs_pkg::BOOT_DONE;
          end
        end
        sgs_pkg::BOOT_ROM0:
        // family byte of the image must match our own
        begin
          if (romNoAck)
          begin
            romRdReq_q  <= 1'b0;
            bootStart_q <= 1'b1;
            bootState_q <= sgs_pkg::BOOT_DONE;
          end
          else if (romRdDone && romRdData == FAMILY_CODE)
          begin
            romAddr_q   <= sgs_pkg::ADDR_IDENT;
            bootState_q <= sgs_pkg::BOOT_ROM1;
          end
          else if (romRdDone)
          begin
            romRdReq_q  <= 1'b0;
            bootStart_q <= 1'b1;
            bootState_q <= sgs_pkg::BOOT_DONE;
          end
        end
        sgs_pkg::BOOT_ROM1:
        // upper nibble of the image identity byte
        begin
          if (romNoAck)
          begin
            romRdReq_q  <= 1'b0;
            bootStart_q <= 1'b1;
            bootState_q <= sgs_pkg::BOOT_DONE;
          end
          else if (romRdDone && romRdData[sgs_pkg::ID_LSB +: 4] == ROM_ID_EXPECT)
          begin
            romAddr_q   <= sgs_pkg::ADDR_GCTL0;
            bootState_q <= sgs_pkg::BOOT_ROM2;
          end
          else if (romRdDone)
          begin
            romRdReq_q  <= 1'b0;
            bootStart_q <= 1'b1;
            bootState_q <= sgs_pkg::BOOT_DONE;
          end
        end
        sgs_pkg::BOOT_ROM2:
        // only this block's writable control byte is taken from the image
        begin
          if (romNoAck || romRdDone)
          begin
            romRdReq_q    <= 1'b0;
            romLoad_q     <= romRdDone;
            romLoadData_q <= romRdData;
            bootStart_q   <= 1'b1;
            bootState_q   <= sgs_pkg::BOOT_DONE;
          end
        end
        sgs_pkg::BOOT_DONE:
          romRdReq_q <= 1'b0;
        default:
          bootState_q <= sgs_pkg::BOOT_DONE;
      endcase
    end
  end

  // serial management frame receiver and read answer
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      smiState_q  <= sgs_pkg::SMI_PRE;
      preCnt_q    <= 6'h00;
      bitCnt_q    <= 5'h00;
      hdr_q       <= 11'h000;
      wrShift_q   <= 15'h0000;
      rdShift_q   <= 16'h0000;
      frameAddr_q <= 8'h00;
      isRd_q      <= 1'b0;
      isWr_q      <= 1'b0;
      mdioOut_q   <= 1'b0;
      mdioOe_q    <= 1'b0;
      wrStb_q     <= 1'b0;
      wrAddr_q    <= 8'h00;
      wrData_q    <= 8'h00;
    end
    else
    begin
      wrStb_q <= 1'b0;
      if (mdcRise)
      begin
        case (smiState_q)
          sgs_pkg::SMI_PRE:
          // count ones; a zero after enough ones is the first start bit
          begin
            if (mdioS_q[2])
            begin
              if (preCnt_q != sgs_pkg::PREAMBLE_ONES)
                preCnt_q <= preCnt_q + 6'h01;
            end
            else if (preCnt_q == sgs_pkg::PREAMBLE_ONES)
              smiState_q <= sgs_pkg::SMI_ST;
            else
              preCnt_q <= 6'h00;
          end
          sgs_pkg::SMI_ST:
          begin
            preCnt_q <= 6'h00;
            bitCnt_q <= 5'h00;
            smiState_q <= mdioS_q[2] ? sgs_pkg::SMI_HDR : sgs_pkg::SMI_PRE;
          end
          sgs_pkg::SMI_HDR:
          // opcode, five address bits, five register bits
          begin
            hdr_q    <= {hdr_q[9:0], mdioS_q[2]};
            bitCnt_q <= bitCnt_q + 5'h01;
            if (bitCnt_q == sgs_pkg::HDR_LAST)
            begin
              // phy bits two and one sit at hdr_q[6:5] once the last register bit arrives
              isRd_q <= hdr_q[10:9] == sgs_pkg::OP_READ && hdr_q[6:5] == sgs_pkg::PHY_SEL;
              isWr_q <= hdr_q[10:9] == sgs_pkg::OP_WRITE && hdr_q[6:5] == sgs_pkg::PHY_SEL;
              frameAddr_q <= {hdr_q[8:7], hdr_q[4], hdr_q[3:0], mdioS_q[2]};
              rdShift_q   <= {sgs_pkg::READ_ZERO,
                              regRead({hdr_q[8:7], hdr_q[4], hdr_q[3:0], mdioS_q[2]})};
              bitCnt_q    <= 5'h00;
              smiState_q  <= sgs_pkg::SMI_TA;
            end
          end
          sgs_pkg::SMI_TA:
          // first turnaround bit left to the host, second driven low on a read
          begin
            bitCnt_q <= bitCnt_q + 5'h01;
            if (bitCnt_q != sgs_pkg::TA_LAST)
            begin
              mdioOe_q  <= isRd_q;
              mdioOut_q <= 1'b0;
            end
            else
            begin
              mdioOut_q  <= rdShift_q[15];
              rdShift_q  <= {rdShift_q[14:0], 1'b0};
              bitCnt_q   <= 5'h00;
              smiState_q <= sgs_pkg::SMI_DAT;
            end
          end
          sgs_pkg::SMI_DAT:
          // sixteen data bits; the pin is released after the last
          begin
            bitCnt_q  <= bitCnt_q + 5'h01;
            wrShift_q <= {wrShift_q[13:0], mdioS_q[2]};
            mdioOut_q <= rdShift_q[15];
            rdShift_q <= {rdShift_q[14:0], 1'b0};
            if (bitCnt_q == sgs_pkg::DATA_LAST)
            begin
              mdioOe_q   <= 1'b0;
              wrStb_q    <= isWr_q;
              wrAddr_q   <= frameAddr_q;
              wrData_q   <= {wrShift_q[6:0], mdioS_q[2]};
              preCnt_q   <= 6'h00;
              smiState_q <= sgs_pkg::SMI_PRE;
            end
          end
          default:
            smiState_q <= sgs_pkg::SMI_PRE;
        endcase
      end
    end
  end

  // start bit: host write wins; auto start only comes from the sequencer
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      startBit_q <= 1'b0;
    else if (wrStb_q && wrAddr_q == sgs_pkg::ADDR_IDENT)
      startBit_q <= wrData_q[sgs_pkg::START_BIT];
    else if (bootStart_q)
      startBit_q <= 1'b1;
  end

  // back-off select, from host or from a checked image
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      backoff_q <= 1'b0;
    else if (wrStb_q && wrAddr_q == sgs_pkg::ADDR_GCTL0)
      backoff_q <= wrData_q[sgs_pkg::BACKOFF_BIT];
    else if (romLoad_q)
      backoff_q <= romLoadData_q[sgs_pkg::BACKOFF_BIT];
  end

  // a kick while a purge already runs is folded into that purge
  assign lKick = wrStb_q && wrAddr_q == sgs_pkg::ADDR_GCTL0 && wrData_q[sgs_pkg::LPURGE_BIT];
  assign fKick = wrStb_q && wrAddr_q == sgs_pkg::ADDR_GCTL0 && wrData_q[sgs_pkg::FPURGE_BIT];

  // purge flags: set wins over the engine's done in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      lPurge_q <= 1'b0;
      fPurge_q <= 1'b0;
      lPulse_q <= 1'b0;
      fPulse_q <= 1'b0;
    end
    else
    begin
      lPurge_q <= lKick || (lPurge_q && !learnedPurgeDone);
      fPurge_q <= fKick || (fPurge_q && !fixedPurgeDone);
      lPulse_q <= lKick && !lPurge_q;
      fPulse_q <= fKick && !fPurge_q;
    end
  end

  // ports whose learning is off at the kick; the table engine purges only these
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      mask_q <= 5'h00;
    else if ((lKick && !lPurge_q) || (fKick && !fPurge_q))
      mask_q <= portLearnOff;
  end

  assign smiDataOut        = mdioOut_q;
  assign smiDataOe         = mdioOe_q;
  assign romRdReq          = romRdReq_q;
  assign romAddr           = romAddr_q;
  assign learnedPurgeStart = lPulse_q;
  assign fixedPurgeStart   = fPulse_q;
  assign purgePortMask     = mask_q;
  assign switchEnable      = startBit_q;
  assign backoffAltEnable  = backoff_q;

endmodule
`default_nettype wire

// *** verification/sgs_global_regs_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module sgs_global_regs_sva (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       mode_strap_high,
  input wire logic       mode_strap_low,
  input wire logic       romRdReq,
  input wire logic [7:0] romAddr,
  input wire logic       romRdDone,
  input wire logic       romNoAck,
  input wire logic [4:0] portLearnOff,
  input wire logic       learnedPurgeStart,
  input wire logic       fixedPurgeStart,
  input wire logic [4:0] purgePortMask,
  input wire logic       switchEnable,
  input wire logic       backoffAltEnable
);
  default clocking cb @(posedge clk_sys); endclocking
  // last image byte accepted: the load is over
  sequence lastByteOk;
    romRdReq && romRdDone && romAddr == 8'h02;
  endsequence
  // no device answered the byte read
  sequence romGiveUp;
    romRdReq && romNoAck;
  endsequence
  lpurge_pulse_a: assert property (disable iff (!rst_n) learnedPurgeStart |=> !learnedPurgeStart)
    else $error("learned purge start held too long");
  fpurge_pulse_a: assert property (disable iff (!rst_n) fixedPurgeStart |=> !fixedPurgeStart)
    else $error("fixed purge start held too long");
  purge_mask_a: assert property (disable iff (!rst_n) (learnedPurgeStart || fixedPurgeStart) |->
    purgePortMask == $past(portLearnOff)) else $error("purge port mask not the learning-off set");
  rom_hold_a: assert property (disable iff (!rst_n) romRdReq && !romRdDone && !romNoAck |=>
    romRdReq && $stable(romAddr)) else $error("eeprom request dropped before answer");
  host_no_rom_a: assert property (disable iff (!rst_n) (mode_strap_high || mode_strap_low) |->
    !romRdReq) else $error("eeprom read in a host strap mode");
  load_start_a: assert property (disable iff (!rst_n) lastByteOk |-> ##2 switchEnable)
    else $error("no start after a good image");
  noack_start_a: assert property (disable iff (!rst_n) romGiveUp |-> ##[1:2] switchEnable)
    else $error("no start after missing eeprom");
  noack_keep_a: assert property (disable iff (!rst_n) romGiveUp |=> !backoffAltEnable [*3])
    else $error("defaults lost without eeprom");
  reset_zero_a: assert property (!rst_n |=> !switchEnable && !backoffAltEnable && !romRdReq
    && !learnedPurgeStart && !fixedPurgeStart) else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// *** verification/sgs_far_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module sgs_far_model (
  input  wire logic        clk_sys,
  input  wire logic        romRdReq,
  input  wire logic [7:0]  romAddr,
  input  wire logic [23:0] romImage,
  input  wire logic        noRom,
  input  wire logic [11:0] purgeWait,
  output logic [7:0]       romRdData,
  output logic             romRdDone,
  output logic             romNoAck,
  input  wire logic        learnedPurgeStart,
  input  wire logic        fixedPurgeStart,
  output logic             learnedPurgeDone,
  output logic             fixedPurgeDone
);
  logic [2:0]  romWait; // answer delay, differs per byte so slow replies occur
  logic [11:0] lCnt;    // learned purge busy count
  logic [11:0] fCnt;    // fixed purge busy count
  initial
  begin
    {romWait, lCnt, fCnt, romRdDone, romNoAck, learnedPurgeDone, fixedPurgeDone} = '0;
    romRdData = 8'h00;
  end
  // eeprom byte reads; data toggles when not valid so stale bytes never look good
  always @(posedge clk_sys)
  begin
    romRdDone <= 1'b0;
    romNoAck <= 1'b0;
    romRdData <= ~romRdData;
    if (romRdReq && !romRdDone && !romNoAck)
    begin
      romWait <= romWait + 3'h1;
      if (romWait == romAddr[2:0] + 3'h1)
      begin
        romWait <= 3'h0;
        romNoAck <= noRom;
        romRdDone <= !noRom;
        romRdData <= romImage[8'd23 - 8'd8 * romAddr -: 8];
      end
    end
  end
  // table engine: purge takes purgeWait clocks, then one done pulse
  always @(posedge clk_sys)
  begin
    lCnt <= learnedPurgeStart ? purgeWait : (lCnt != 12'h000) ? lCnt - 12'h001 : lCnt;
    fCnt <= fixedPurgeStart ? purgeWait : (fCnt != 12'h000) ? fCnt - 12'h001 : fCnt;
    learnedPurgeDone <= (lCnt == 12'h001);
    fixedPurgeDone <= (fCnt == 12'h001);
  end
endmodule
`default_nettype wire

// *** verification/sgs_global_regs_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module sgs_global_regs_bench;
  localparam logic [7:0] FAM = 8'hA5; // arbitrary value
  localparam logic [3:0] CID = 4'h6;  // arbitrary value
  localparam logic [2:0] REV = 3'h1;  // arbitrary value
  localparam logic [3:0] RID = 4'h3;  // arbitrary value
  logic        clk_sys, rst_n, mode_strap_high, mode_strap_low, smiClk, hostBit, hostOe, noRom;
  logic        smiDataOut, smiDataOe, romRdReq, romRdDone, romNoAck, learnedPurgeDone, fixedPurgeDone;
  logic        learnedPurgeStart, fixedPurgeStart, switchEnable, backoffAltEnable, smiDataIn;
  logic [7:0]  romAddr, romRdData;
  logic [4:0]  portLearnOff, purgePortMask, maskSeen;
  logic [23:0] romImage;
  logic [11:0] purgeWait;
  logic [15:0] rd;
  int          err_total, check_count, lPul, fPul, l0, f0, cycles, seedSink;
  // pulled-up management data line shared by host and device
  assign smiDataIn = (smiDataOe ? smiDataOut : 1'b1) & (hostOe ? hostBit : 1'b1);
  sgs_global_regs #(.FAMILY_CODE(FAM), .CHIP_ID(CID), .SILICON_REV(REV), .ROM_ID_EXPECT(RID)) i_sgs_global_regs (
    .clk_sys, .rst_n, .mode_strap_high, .mode_strap_low, .smiClk, .smiDataIn, .smiDataOut, .smiDataOe,
    .romRdReq, .romAddr, .romRdData, .romRdDone, .romNoAck, .portLearnOff, .learnedPurgeDone,
    .fixedPurgeDone, .learnedPurgeStart, .fixedPurgeStart, .purgePortMask, .switchEnable, .backoffAltEnable);
  sgs_far_model i_sgs_far_model (.clk_sys, .romRdReq, .romAddr, .romImage, .noRom, .purgeWait, .romRdData,
    .romRdDone, .romNoAck, .learnedPurgeStart, .fixedPurgeStart, .learnedPurgeDone, .fixedPurgeDone);
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // purge kicks seen at the port, with the mask of the kick
  always @(posedge clk_sys)
  begin
    cycles++;
    if (learnedPurgeStart) lPul++;
    if (fixedPurgeStart) fPul++;
    if (learnedPurgeStart || fixedPurgeStart) maskSeen = purgePortMask;
    if (cycles == 60000)
    begin
      err_total++;
      complete_run();
    end
  end
  function automatic logic [7:0] identExp(input logic s);
    return {CID, REV, s};
  endfunction
  function automatic logic [7:0] gctlExp(input logic b, input logic l, input logic f);
    return {b, 1'b0, l, f, 2'b11, 2'b00};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one whole frame with fresh preamble; slow clock, about 10 system clocks a half
  task automatic smi(input logic [1:0] op, input logic [7:0] addr, input logic [7:0] wd);
    logic [63:0] frame;
    frame = {32'hFFFF_FFFF, 2'b01, op, addr[7:6], 2'b11, addr[5], addr[4:0], 2'b10, 8'($urandom), wd};
    for (int i = 64; i >= 0; i--)
    begin
      smiClk <= 1'b0;
      hostBit <= (i > 0) ? frame[i-1] : 1'b1;
      hostOe <= (i > 18) || (op == sgs_pkg::OP_WRITE && i > 0);
      repeat (10) @(posedge clk_sys);
      // the host takes the shared line just before its own rising edge
      if (i > 0 && i <= 16) rd[i-1] = smiDataIn;
      smiClk <= 1'b1;
      repeat (10) @(posedge clk_sys);
    end
    repeat (5) @(posedge clk_sys);
  endtask
  task automatic rdChk(input logic [7:0] addr, input logic [7:0] exp);
    smi(sgs_pkg::OP_READ, addr, 8'h00);
    check(rd[15:8], 8'h00);
    check(rd[7:0], exp);
    check(8'(smiDataOe), 8'h00);
  endtask
  task automatic boot(input logic [1:0] strap, input logic [23:0] img, input logic none);
    rst_n <= 1'b0;
    {mode_strap_high, mode_strap_low} <= strap;
    romImage <= img;
    noRom <= none;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (150) @(posedge clk_sys);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    {rst_n, mode_strap_high, mode_strap_low, smiClk, hostBit, hostOe, noRom} = 7'h08;
    {err_total, check_count, lPul, fPul, cycles} = '0;
    portLearnOff = 5'h00;
    romImage = 24'h000000;
    purgeWait = 12'h010;
    seedSink = $urandom(50);
    @(posedge clk_sys);
    // good image: load back-off and auto start
    boot(2'b00, {FAM, RID, 4'h0, 8'h80}, 1'b0);
    check(8'(switchEnable), 8'h01);
    check(8'(backoffAltEnable), 8'h01);
    rdChk(8'h02, gctlExp(1'b1, 1'b0, 1'b0));
    rdChk(8'h00, FAM);
    rdChk(8'h01, identExp(1'b1));
    $display("test auto load done");
    // failed family or id nibble, then no eeprom: defaults, still start
    for (int k = 0; k < 3; k++)
    begin
      boot(2'b00, (k == 0) ? {FAM ^ 8'h01, RID, 4'h0, 8'h80} : {FAM, RID ^ 4'h1, 4'h0, 8'h80}, k == 2);
      check(8'(switchEnable), 8'h01);
      check(8'(backoffAltEnable), 8'h00);
    end
    $display("test auto defaults done");
    // both host strap modes: idle until the start bit is written
    for (int k = 1; k < 3; k++)
    begin
      boot(2'(k), {FAM, RID, 4'h0, 8'h80}, 1'b0);
      check(8'(switchEnable), 8'h00);
      smi(sgs_pkg::OP_WRITE, 8'h01, 8'($urandom) | 8'h01);
      check(8'(switchEnable), 8'h01);
      rdChk(8'h01, identExp(1'b1));
      smi(sgs_pkg::OP_WRITE, 8'h01, 8'($urandom) & 8'hFE);
      check(8'(switchEnable), 8'h00);
    end
    $display("test host start done");
    smi(sgs_pkg::OP_WRITE, 8'h00, 8'($urandom));
    rdChk(8'h00, FAM);
    smi(sgs_pkg::OP_WRITE, 8'h02, 8'h8C | (8'($urandom) & 8'h03));
    check(8'(backoffAltEnable), 8'h01);
    rdChk(8'h02, gctlExp(1'b1, 1'b0, 1'b0));
    rdChk(8'h03, 8'h00);
    // purge kicks: flag stands while busy, clears after done
    for (int k = 0; k < 2; k++)
    begin
      portLearnOff <= (k == 0) ? 5'h1F : 5'($urandom);
      purgeWait <= 12'hBB8;
      l0 = lPul;
      f0 = fPul;
      smi(sgs_pkg::OP_WRITE, 8'h02, 8'h8C | (8'h20 >> k));
      check({4'(lPul - l0), 4'(fPul - f0)}, (k == 0) ? 8'h10 : 8'h01);
      check(8'(maskSeen), 8'(portLearnOff));
      rdChk(8'h02, gctlExp(1'b1, k == 0, k == 1));
      repeat (2500) @(posedge clk_sys);
      rdChk(8'h02, gctlExp(1'b1, 1'b0, 1'b0));
    end
    $display("test purge done");
    complete_run();
  end
endmodule
bind sgs_global_regs sgs_global_regs_sva i_sgs_global_regs_sva (.clk_sys, .rst_n, .mode_strap_high,
  .mode_strap_low, .romRdReq, .romAddr, .romRdDone, .romNoAck, .portLearnOff, .learnedPurgeStart,
  .fixedPurgeStart, .purgePortMask, .switchEnable, .backoffAltEnable);
`default_nettype wire
